//--- src/edfd_map.vh
`ifndef EDFD_MAP_VH
`define EDFD_MAP_VH

// ********************************
// Register byte offsets
// ********************************
`define EDFD_OFS_CTRL 8'h00
`define EDFD_OFS_EC_THR 8'h04
`define EDFD_OFS_EC_SLOPE 8'h08
`define EDFD_OFS_RATIO 8'h0C
`define EDFD_OFS_PARAB 8'h10
`define EDFD_OFS_NOMINAL 8'h14
`define EDFD_OFS_U0_EARTHED 8'h18
`define EDFD_OFS_U0_UNEARTHED 8'h1C
`define EDFD_OFS_REL_DELAY 8'h20
`define EDFD_OFS_STATUS 8'h24

// ********************************
// Control fields
// ********************************
`define EDFD_CTRL_EARTHED 0
`define EDFD_CTRL_AND_MODE 1

// ********************************
// Reset values
// ********************************
`define EDFD_RST_CTRL 2'h1
`define EDFD_RST_EC_THR 16'h0100
`define EDFD_RST_EC_SLOPE 8'h02
`define EDFD_RST_RATIO 8'h10
`define EDFD_RST_PARAB 5'h0C
`define EDFD_RST_NOMINAL 16'h1000
`define EDFD_RST_U0 16'hFFFF
`define EDFD_RST_REL_DELAY 16'h0028

// ********************************
// Encodings and scaling
// ********************************
`define EDFD_THR_INFINITE 16'hFFFF
`define EDFD_SLOPE_SHIFT 4
`define EDFD_RATIO_SHIFT 4
`define EDFD_MIN_REL_DIV 3'h5
`define EDFD_DROP_DIV 5'h14

`endif

//--- src/edfd_hyst_cmp.v
`timescale 1ns/1ps
`include "edfd_map.vh"

// ****************************************
// Comparator with dropout at about 95 %
// ****************************************
module edfd_hyst_cmp #(
    parameter W = 24
) (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire tick,
    input wire [W-1:0] val,
    input wire [W-1:0] thr,
    input wire inf,
    output reg pu_r
);

    wire [W-1:0] drop_lvl;
    reg pu_nxt;

    // Thr/20 off the top keeps the band proportional to the setting
    assign drop_lvl = thr - thr / `EDFD_DROP_DIV;

    always @* begin
        pu_nxt = pu_r;
        if (inf) begin
            pu_nxt = 1'b0;
        end else if (!pu_r && val > thr) begin
            pu_nxt = 1'b1;
        end else if (pu_r && val < drop_lvl) begin
            pu_nxt = 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pu_r <= 1'b0;
        end else if (ce && tick) begin
            pu_r <= pu_nxt;
        end
    end

endmodule // edfd_hyst_cmp

//--- src/edfd_delay.v
`timescale 1ns/1ps

// ****************************************
// Sample-counting release delay
// ****************************************
module edfd_delay (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire tick,
    input wire run,
    input wire [15:0] limit,
    output reg done_r
);

    reg [15:0] cnt_r;

    // Restarts whenever run drops, so each new single-phase fault waits anew
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 16'h0000;
            done_r <= 1'b0;
        end else if (ce && tick) begin
            if (!run) begin
                cnt_r <= 16'h0000;
                done_r <= 1'b0;
            end else if (cnt_r >= limit) begin
                done_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

endmodule // edfd_delay

//--- src/edfd_top.v
`timescale 1ns/1ps
`include "edfd_map.vh"

// Notes on behaviour
// - Earth current is magnitude of summed phase phasors against a threshold.
// - Earth current threshold grows with the largest phase current.
// - Earth current stage drops out below about 95 % of threshold.
// - Sequence stage picks up when I0/I2 exceeds the set ratio.
// - A parabolic term in I2 desensitises the sequence stage.
// - Sequence stage needs both 3I0 and 3I2 at least 0.2 nominal.
// - Displacement voltage compared to threshold, dropout near 95 %.
// - Infinite earthed voltage threshold disables the voltage criterion.
// - Earthed systems combine current and voltage by OR, or AND if set.
// - Voltage criterion disabled: current alone still works under saturation.
// - Saturation with voltage enabled: voltage criterion is mandatory.
// - Earth fault flag only steers downstream, never a general pickup.
// - Earth fault alarm only while general fault detection is active.
// - Single-pole open in earthed systems adds magnitude and angle checks.
// - Non-earthed systems ignore displacement voltage for earth detection.
// - Non-earthed single-phase pickup blocked until release delay expires.
// - Unearthed displacement stage already up: no release delay applied.
// - Unearthed displacement stage plus multi-phase pickup is double earth fault.
module edfd_top (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire sample_en,
    input wire [15:0] i1_re,
    input wire [15:0] i1_im,
    input wire [15:0] i2_re,
    input wire [15:0] i2_im,
    input wire [15:0] i3_re,
    input wire [15:0] i3_im,
    input wire [15:0] neg_seq_mag,
    input wire [15:0] u0_mag,
    input wire [2:0] ct_sat,
    input wire single_pole_open,
    input wire spo_angle_ok,
    input wire [2:0] phase_pu,
    input wire general_fd,
    output reg earth_fault,
    output reg earth_fault_alarm,
    output reg fd_release,
    output reg double_earth_fault
);

    // ********************************
    // Helper functions
    // ********************************
    function [17:0] abs18;
        input [17:0] v;
        begin
            abs18 = v[17] ? (~v + 18'h0_0001) : v;
        end
    endfunction

    // Max plus half min: cheap magnitude, within about 12 % of true
    function [17:0] mag_est;
        input [17:0] re;
        input [17:0] im;
        reg [17:0] a;
        reg [17:0] b;
        begin
            a = abs18(re);
            b = abs18(im);
            mag_est = (a > b) ? (a + (b >> 1)) : (b + (a >> 1));
        end
    endfunction

    function [17:0] sx;
        input [15:0] v;
        begin
            sx = {{2{v[15]}}, v};
        end
    endfunction

    function [17:0] max18;
        input [17:0] a;
        input [17:0] b;
        begin
            max18 = (a > b) ? a : b;
        end
    endfunction

    // ********************************
    // Register bus
    // ********************************
    reg [1:0] ctrl_r;
    reg [15:0] ec_thr_r;
    reg [7:0] ec_slope_r;
    reg [7:0] ratio_r;
    reg [4:0] parab_r;
    reg [15:0] nominal_r;
    reg [15:0] u0_earthed_r;
    reg [15:0] u0_unearthed_r;
    reg [15:0] rel_delay_r;
    reg wr_pend_r;
    reg rd_pend_r;
    reg [7:0] addr_r;
    reg [31:0] rd_val;
    wire [7:0] status_w;
    wire take;

    assign take = hsel && hready && htrans[1];

    always @* begin
        case (addr_r)
            `EDFD_OFS_CTRL: rd_val = {30'h0000_0000, ctrl_r};
            `EDFD_OFS_EC_THR: rd_val = {16'h0000, ec_thr_r};
            `EDFD_OFS_EC_SLOPE: rd_val = {24'h00_0000, ec_slope_r};
            `EDFD_OFS_RATIO: rd_val = {24'h00_0000, ratio_r};
            `EDFD_OFS_PARAB: rd_val = {27'h000_0000, parab_r};
            `EDFD_OFS_NOMINAL: rd_val = {16'h0000, nominal_r};
            `EDFD_OFS_U0_EARTHED: rd_val = {16'h0000, u0_earthed_r};
            `EDFD_OFS_U0_UNEARTHED: rd_val = {16'h0000, u0_unearthed_r};
            `EDFD_OFS_REL_DELAY: rd_val = {16'h0000, rel_delay_r};
            `EDFD_OFS_STATUS: rd_val = {24'h00_0000, status_w};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Reads take one wait state so a write just before is always seen
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            if (rd_pend_r) begin
                hrdata <= rd_val;
                hreadyout <= 1'b1;
                rd_pend_r <= 1'b0;
            end else begin
                wr_pend_r <= take && hwrite;
                rd_pend_r <= take && !hwrite;
                hreadyout <= !(take && !hwrite);
                if (take) begin
                    addr_r <= {haddr[7:2], 2'b00};
                end
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `EDFD_RST_CTRL;
            ec_thr_r <= `EDFD_RST_EC_THR;
            ec_slope_r <= `EDFD_RST_EC_SLOPE;
            ratio_r <= `EDFD_RST_RATIO;
            parab_r <= `EDFD_RST_PARAB;
            nominal_r <= `EDFD_RST_NOMINAL;
            u0_earthed_r <= `EDFD_RST_U0;
            u0_unearthed_r <= `EDFD_RST_U0;
            rel_delay_r <= `EDFD_RST_REL_DELAY;
        end else if (ce && wr_pend_r) begin
            case (addr_r)
                `EDFD_OFS_CTRL: ctrl_r <= hwdata[1:0];
                `EDFD_OFS_EC_THR: ec_thr_r <= hwdata[15:0];
                `EDFD_OFS_EC_SLOPE: ec_slope_r <= hwdata[7:0];
                `EDFD_OFS_RATIO: ratio_r <= hwdata[7:0];
                `EDFD_OFS_PARAB: parab_r <= hwdata[4:0];
                `EDFD_OFS_NOMINAL: nominal_r <= hwdata[15:0];
                `EDFD_OFS_U0_EARTHED: u0_earthed_r <= hwdata[15:0];
                `EDFD_OFS_U0_UNEARTHED: u0_unearthed_r <= hwdata[15:0];
                `EDFD_OFS_REL_DELAY: rel_delay_r <= hwdata[15:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ********************************
    // Earth current stage
    // ********************************
    wire [17:0] sum_re;
    wire [17:0] sum_im;
    wire [17:0] ie_mag;
    wire [17:0] iph_max;
    wire [25:0] slope_prod;
    wire [23:0] ec_eff_thr;
    wire ec_pu;

    assign sum_re = sx(i1_re) + sx(i2_re) + sx(i3_re);
    assign sum_im = sx(i1_im) + sx(i2_im) + sx(i3_im);
    assign ie_mag = mag_est(sum_re, sum_im);
    assign iph_max = max18(mag_est(sx(i1_re), sx(i1_im)),
        max18(mag_est(sx(i2_re), sx(i2_im)), mag_est(sx(i3_re), sx(i3_im))));
    assign slope_prod = iph_max * ec_slope_r;
    // Lifts the threshold under heavy load to ride out unequal CT errors
    assign ec_eff_thr = {8'h00, ec_thr_r} + slope_prod[25:`EDFD_SLOPE_SHIFT];

    edfd_hyst_cmp #(
        .W(24)
    ) u_ec (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick(sample_en),
        .val({6'h00, ie_mag}),
        .thr(ec_eff_thr),
        .inf(1'b0),
        .pu_r(ec_pu)
    );

    // ********************************
    // Sequence ratio stage
    // ********************************
    wire [35:0] seq_lhs;
    wire [35:0] seq_rhs;
    wire [31:0] i2_sq;
    wire [23:0] ratio_prod;
    wire [20:0] i0_x5;
    wire [18:0] i2_x5;
    wire seq_min_ok;
    reg seq_pu_r;

    assign seq_lhs = {14'h0000, ie_mag, 4'h0};
    assign i2_sq = neg_seq_mag * neg_seq_mag;
    // Full-width product: a large I2 must not wrap into a small stabilising term
    assign ratio_prod = ratio_r * neg_seq_mag;
    assign seq_rhs = {12'h000, ratio_prod} + {4'h0, i2_sq >> parab_r};
    assign i0_x5 = ie_mag * `EDFD_MIN_REL_DIV;
    assign i2_x5 = neg_seq_mag * `EDFD_MIN_REL_DIV;
    assign seq_min_ok = (i0_x5 >= {5'h00, nominal_r}) &&
        (i2_x5 >= {3'h0, nominal_r});

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_pu_r <= 1'b0;
        end else if (ce && sample_en) begin
            seq_pu_r <= seq_min_ok && (seq_lhs > seq_rhs);
        end
    end

    // ********************************
    // Displacement voltage stages
    // ********************************
    wire u_dis;
    wire ue_pu;
    wire uu_pu;

    assign u_dis = (u0_earthed_r == `EDFD_THR_INFINITE);

    edfd_hyst_cmp #(
        .W(16)
    ) u_ue (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick(sample_en),
        .val(u0_mag),
        .thr(u0_earthed_r),
        .inf(u_dis),
        .pu_r(ue_pu)
    );

    edfd_hyst_cmp #(
        .W(16)
    ) u_uu (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick(sample_en),
        .val(u0_mag),
        .thr(u0_unearthed_r),
        .inf(u0_unearthed_r == `EDFD_THR_INFINITE),
        .pu_r(uu_pu)
    );

    // ********************************
    // Combination logic
    // ********************************
    wire earthed;
    wire and_mode;
    wire i_crit;
    wire any_sat;
    wire [1:0] npu;
    wire single_pu;
    wire multi_pu;
    wire delay_done;
    reg ef_nxt;
    reg rel_nxt;

    assign earthed = ctrl_r[`EDFD_CTRL_EARTHED];
    assign and_mode = ctrl_r[`EDFD_CTRL_AND_MODE];
    assign i_crit = ec_pu || seq_pu_r;
    assign any_sat = |ct_sat;
    assign npu = {1'b0, phase_pu[0]} + {1'b0, phase_pu[1]} + {1'b0, phase_pu[2]};
    assign single_pu = (npu == 2'd1);
    assign multi_pu = (npu > 2'd1);

    always @* begin
        ef_nxt = 1'b0;
        if (!earthed) begin
            ef_nxt = i_crit;
        end else if (single_pole_open) begin
            // Load current in the healthy poles must not look like an earth fault
            ef_nxt = ec_pu && spo_angle_ok && (u_dis || ue_pu);
        end else if (u_dis) begin
            ef_nxt = i_crit;
        end else if (any_sat) begin
            ef_nxt = ue_pu && (!and_mode || i_crit);
        end else if (and_mode) begin
            ef_nxt = i_crit && ue_pu;
        end else begin
            ef_nxt = i_crit || ue_pu;
        end
    end

    edfd_delay u_rel (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick(sample_en),
        .run(!earthed && single_pu),
        .limit(rel_delay_r),
        .done_r(delay_done)
    );

    // Suppression hides earth fault initiation transients
    always @* begin
        rel_nxt = 1'b1;
        if (!earthed && single_pu && !uu_pu && !delay_done) begin
            rel_nxt = 1'b0;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            earth_fault <= 1'b0;
            earth_fault_alarm <= 1'b0;
            fd_release <= 1'b0;
            double_earth_fault <= 1'b0;
        end else if (ce && sample_en) begin
            // Steering only; general pickup is decided downstream
            earth_fault <= ef_nxt;
            earth_fault_alarm <= ef_nxt && general_fd;
            fd_release <= rel_nxt;
            double_earth_fault <= !earthed && uu_pu && multi_pu;
        end
    end

    assign status_w = {double_earth_fault, fd_release, earth_fault, delay_done,
        uu_pu, ue_pu, seq_pu_r, ec_pu};

endmodule // edfd_top

//--- testbench/edfd_checker.sv
`timescale 1ns/1ps

// ****************************************
// Port checker
// ****************************************
module edfd_checker (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire sample_en,
    input wire [2:0] phase_pu,
    input wire general_fd,
    input wire earth_fault,
    input wire earth_fault_alarm,
    input wire fd_release,
    input wire double_earth_fault
);
    reg [1:0] ns_cnt_r;
    reg multi_q1_r;
    reg multi_q2_r;
    wire multi = phase_pu inside {3'h3, 3'h5, 3'h6, 3'h7};

    // Stage states lag one sample, so keep two samples of history
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ns_cnt_r <= 2'h0;
            multi_q1_r <= 1'b0;
            multi_q2_r <= 1'b0;
        end else if (ce && sample_en) begin
            ns_cnt_r <= $onehot(phase_pu) ? 2'h0 : ns_cnt_r + {1'b0, ns_cnt_r != 2'h3};
            multi_q1_r <= multi;
            multi_q2_r <= multi_q1_r;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_tick;
        ce && sample_en;
    endsequence
    sequence s_read;
        ce && hsel && hready && htrans[1] && !hwrite;
    endsequence

    chk_alarm_needs_ef: assert property (earth_fault_alarm |-> earth_fault)
        else $error("alarm without earth fault");
    chk_alarm_gated: assert property (s_tick ##0 !general_fd |=> !earth_fault_alarm)
        else $error("alarm without general detection");
    chk_hold_idle: assert property (!(ce && sample_en) |=> $stable(earth_fault)
        && $stable(fd_release) && $stable(double_earth_fault) && $stable(earth_fault_alarm))
        else $error("flags moved between samples");
    chk_release_free: assert property (s_tick ##0 (!$onehot(phase_pu)
        && ns_cnt_r >= 2'h2) |=> fd_release)
        else $error("release held without single pickup");
    chk_dbl_multi: assert property ($rose(double_earth_fault)
        |-> multi_q1_r || multi_q2_r)
        else $error("double fault without multi pickup");
    chk_read_wait: assert property (s_read |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    chk_read_cause: assert property ($fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite))
        else $error("wait state without read");
    chk_resp_okay: assert property (!hresp)
        else $error("response not okay");
endmodule // edfd_checker

bind edfd_top edfd_checker chk_u (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .sample_en, .phase_pu, .general_fd, .earth_fault, .earth_fault_alarm,
    .fd_release, .double_earth_fault);

//--- testbench/edfd_meas_model.sv
`timescale 1ns/1ps

// ****************************************
// Measurement channel model
// ****************************************
module edfd_meas_model (
    input wire hclk,
    input wire hresetn,
    input wire [15:0] ie_cmd,
    input wire [15:0] i2_cmd,
    input wire [15:0] u0_cmd,
    output reg sample_en,
    output wire [15:0] i1_re,
    output wire [15:0] i1_im,
    output wire [15:0] i2_re,
    output wire [15:0] i2_im,
    output wire [15:0] i3_re,
    output wire [15:0] i3_im,
    output wire [15:0] neg_seq_mag,
    output wire [15:0] u0_mag
);
    reg [1:0] div_r;

    // Residual current injected on one phase only
    assign i1_re = ie_cmd;
    assign i1_im = 16'h0000;
    assign i2_re = 16'h0000;
    assign i2_im = 16'h0000;
    assign i3_re = 16'h0000;
    assign i3_im = 16'h0000;
    assign neg_seq_mag = i2_cmd;
    assign u0_mag = u0_cmd;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 2'h0;
            sample_en <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            sample_en <= div_r == 2'h3;
        end
    end
endmodule // edfd_meas_model

//--- testbench/edfd_top_tb.sv
`timescale 1ns/1ps
`include "edfd_map.vh"

// ****************************************
// Earth fault detector bench
// ****************************************
module edfd_top_tb;
    reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, general_fd = 1'b0;
    reg single_pole_open = 1'b0, spo_angle_ok = 1'b0, ce = 1'b1;
    reg [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, tmp;
    reg [1:0] htrans = 2'h0;
    reg [2:0] ct_sat = 3'h0, phase_pu = 3'h0;
    reg [15:0] ie_cmd = 16'h0000, i2_cmd = 16'h0000, u0_cmd = 16'h0000;
    wire [31:0] hrdata;
    wire hreadyout, hresp, sample_en, earth_fault, earth_fault_alarm, fd_release;
    wire double_earth_fault;
    wire [15:0] i1_re, i1_im, i2_re, i2_im, i3_re, i3_im, neg_seq_mag, u0_mag;
    integer n_errors = 0, cmp_count = 0;

    edfd_meas_model meas_u (.hclk, .hresetn, .ie_cmd, .i2_cmd, .u0_cmd, .sample_en, .i1_re,
        .i1_im, .i2_re, .i2_im, .i3_re, .i3_im, .neg_seq_mag, .u0_mag);
    edfd_top dut_u (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_en,
        .i1_re, .i1_im, .i2_re, .i2_im, .i3_re, .i3_im, .neg_seq_mag, .u0_mag, .ct_sat,
        .single_pole_open, .spo_angle_ok, .phase_pu, .general_fd, .earth_fault,
        .earth_fault_alarm, .fd_release, .double_earth_fault);

    initial begin
        forever #2.5 hclk = ~hclk;
    end

    task summarize;
        begin
            $display("checks %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Bounded wait for ready (sel 0) or the sample strobe (sel 1)
    task wait_hi(input sel);
        integer k;
        begin
            k = 0;
            @(posedge hclk);
            while ((sel ? sample_en : hreadyout) !== 1'b1) begin
                k = k + 1;
                if (k > 40) begin
                    n_errors = n_errors + 1;
                    summarize;
                end
                @(posedge hclk);
            end
        end
    endtask

    task bus(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            haddr <= {24'h00_0000, a};
            htrans <= 2'b10;
            hwrite <= wr;
            wait_hi(1'b0);
            htrans <= 2'b00;
            hwdata <= d;
            wait_hi(1'b0);
            tmp = hrdata;
        end
    endtask

    task rd(input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0000_0000);
            chk(tmp, e);
        end
    endtask

    task samp(input integer n);
        begin
            repeat (n) wait_hi(1'b1);
            @(negedge hclk);
        end
    endtask

    task meas(input [15:0] ie, input [15:0] i2, input [15:0] u0, input [2:0] pu, input integer n);
        begin
            @(posedge hclk);
            ie_cmd <= ie;
            i2_cmd <= i2;
            u0_cmd <= u0;
            phase_pu <= pu;
            samp(n);
        end
    endtask

    // Packed as {double, release, alarm, earth}
    task flags(input [3:0] e);
        begin
            chk({28'h000_0000, double_earth_fault, fd_release, earth_fault_alarm, earth_fault},
                {28'h000_0000, e});
        end
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`EDFD_OFS_CTRL, 32'h0000_0001);
        rd(`EDFD_OFS_EC_THR, 32'h0000_0100);
        rd(`EDFD_OFS_U0_EARTHED, 32'h0000_FFFF);
        rd(8'h40, 32'h0000_0000);
        bus(1'b1, `EDFD_OFS_REL_DELAY, 32'h0000_0004);
        rd(`EDFD_OFS_REL_DELAY, 32'h0000_0004);
        $display("test registers done");
        meas(16'h0200, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0101);
        @(posedge hclk) general_fd <= 1'b1;
        samp(2);
        flags(4'b0111);
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        meas(16'h0120, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0100);
        bus(1'b1, `EDFD_OFS_EC_SLOPE, 32'h0000_0000);
        samp(3);
        flags(4'b0111);
        meas(16'h00FA, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0111);
        meas(16'h00F0, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0100);
        $display("test earth current done");
        bus(1'b1, `EDFD_OFS_U0_EARTHED, 32'h0000_0100);
        meas(16'h0000, 16'h0000, 16'h0200, 3'h0, 3);
        flags(4'b0111);
        meas(16'h0000, 16'h0000, 16'h00FA, 3'h0, 3);
        flags(4'b0111);
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        bus(1'b1, `EDFD_OFS_CTRL, 32'h0000_0003);
        meas(16'h0000, 16'h0000, 16'h0200, 3'h0, 3);
        flags(4'b0100);
        meas(16'h0200, 16'h0000, 16'h0200, 3'h0, 3);
        flags(4'b0111);
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        bus(1'b1, `EDFD_OFS_CTRL, 32'h0000_0001);
        @(posedge hclk) ct_sat <= 3'h1;
        meas(16'h0200, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0100);
        meas(16'h0200, 16'h0000, 16'h0200, 3'h0, 3);
        flags(4'b0111);
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        bus(1'b1, `EDFD_OFS_U0_EARTHED, 32'h0000_FFFF);
        meas(16'h0200, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0111);
        @(posedge hclk) ct_sat <= 3'h0;
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        @(posedge hclk) single_pole_open <= 1'b1;
        meas(16'h0200, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0100);
        @(posedge hclk) spo_angle_ok <= 1'b1;
        samp(3);
        flags(4'b0111);
        @(posedge hclk) single_pole_open <= 1'b0;
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        $display("test voltage and combination done");
        // Slope this steep keeps the earth current stage out of the way
        bus(1'b1, `EDFD_OFS_EC_SLOPE, 32'h0000_00FF);
        bus(1'b1, `EDFD_OFS_RATIO, 32'h0000_0008);
        meas(16'd1600, 16'd700, 16'h0000, 3'h0, 3);
        flags(4'b0100);
        meas(16'd1600, 16'd3072, 16'h0000, 3'h0, 3);
        flags(4'b0100);
        meas(16'd1600, 16'd2048, 16'h0000, 3'h0, 3);
        flags(4'b0111);
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        $display("test sequence ratio done");
        bus(1'b1, `EDFD_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, `EDFD_OFS_U0_UNEARTHED, 32'h0000_0100);
        bus(1'b1, `EDFD_OFS_U0_EARTHED, 32'h0000_0100);
        meas(16'h0000, 16'h0000, 16'h0000, 3'h1, 2);
        flags(4'b0000);
        samp(6);
        flags(4'b0100);
        meas(16'h0000, 16'h0000, 16'h0200, 3'h0, 3);
        flags(4'b0100);
        meas(16'h0000, 16'h0000, 16'h0200, 3'h2, 2);
        flags(4'b0100);
        meas(16'h0000, 16'h0000, 16'h0200, 3'h3, 3);
        flags(4'b1100);
        // Enable low: inputs drop, every stage and flag must hold
        @(posedge hclk) ce <= 1'b0;
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b1100);
        @(posedge hclk) ce <= 1'b1;
        meas(16'h0000, 16'h0000, 16'h0000, 3'h0, 3);
        flags(4'b0100);
        $display("test unearthed done");
        summarize;
    end
endmodule // edfd_top_tb
